// >>> hw/tcr_pkg.sv
// Package of the transceiver configuration register bank.
// Assumes one 10 MHz system clock and an asynchronous active-high reset.
//
// Contract
// - Sixteen-byte data buffer plus eight control bytes, host readable and writable.
// - Separate byte-wide status register, readable by the host.
// - Contents kept while powered, lost on entering off mode.
// - Power-on through either pin loads every control register default.
// - Receive: threshold 1/2/4/12 bytes or receive error raises interrupt.
// - Transmit: 1/2/4/12 bytes remaining or buffer empty raises interrupt.
// - Threshold field has no effect in full-duplex modes.
// - Control 1 bit 5 selects narrow 3072..4095 or full 0..8191 range.
// - Control 1 bit 4 selects the 433/868 or the 315 band.
// - Control 1 bits 3:1 select idle, transmit, polling, receive, duplex.
// - Control 1 bit 0 routes data through serial pins instead of buffer.
// - Control 2 bits 7:1 hold frequency low part, default 84.
// - Frequency word is thirteen bits wide.
// - Receive: polling bit clear lets a good bit-check raise interrupt.
// - Transmit: polling bit clear enables Manchester, set gives NRZ.
// - Polling/coding bit has no effect in full-duplex modes.
// - Frequency word is low part plus high part from control 3.
// - Serial accesses are ignored while the device is off.
`default_nettype none
package tcr_pkg;
   // ==========================================================
   // Storage geometry
   localparam int BUF_DEPTH   = 16;
   localparam int CTRL_COUNT  = 8;
   localparam int BYTE_W      = 8;
   localparam int SYNTH_WORD_A_W      = 13;
   // ==========================================================
   // Address map: control at 0..7, buffer and status selected by space.
   localparam logic [3:0] CTRL_MODE_IRQ_ADR  = 4'h0;
   localparam logic [3:0] CTRL_SYNTH_WORD_A_LOW_ADR  = 4'h1;
   localparam logic [3:0] CTRL_SYNTH_WORD_A_HIGH_ADR = 4'h2;
   // ==========================================================
   // Control register 1 fields and reset value
   localparam int IRQ_THR_HI   = 7;
   localparam int IRQ_THR_LO   = 6;
   localparam int RANGE_BIT    = 5;
   localparam int BAND_BIT     = 4;
   localparam int MODE_HI      = 3;
   localparam int MODE_LO      = 1;
   localparam int TRANSP_BIT   = 0;
   localparam logic [7:0] CTRL1_RESET = 8'h80;
   // Control register 2 fields and reset value
   localparam int SYNTH_WORD_A_LOW_HI  = 7;
   localparam int SYNTH_WORD_A_LOW_LO  = 1;
   localparam int POLL_BIT     = 0;
   localparam logic [7:0] CTRL2_RESET = 8'ha8;
   // Control register 3: high part bits 7:2, default 3840 = 30*128.
   localparam int SYNTH_WORD_A_HIGH_HI = 7;
   localparam int SYNTH_WORD_A_HIGH_LO = 2;
   localparam logic [7:0] CTRL3_RESET = 8'h7b;
   localparam logic [7:0] CTRL_OTHER_RESET = 8'h00;
   localparam int SYNTH_WORD_A_HIGH_SHIFT = 7;
   // Narrow range: only low three high-part bits count, base 3072.
   localparam logic [12:0] NARROW_BASE = 13'hc00;
   localparam int NARROW_BITS  = 3;
   // ==========================================================
   // Interrupt fill thresholds per code
   localparam logic [4:0] THR_0 = 5'h01;
   localparam logic [4:0] THR_1 = 5'h02;
   localparam logic [4:0] THR_2 = 5'h04;
   localparam logic [4:0] THR_3 = 5'h0c;
   // ==========================================================
   // Operating mode codes
   typedef enum logic [2:0] {
      TCR_IDLE    = 3'h0,
      TCR_TX      = 3'h1,
      TCR_RX_POLL = 3'h2,
      TCR_RX      = 3'h3,
      TCR_FD_MST  = 3'h5,
      TCR_FD_SLV  = 3'h7
   } tcr_mode_t;
   // Access spaces
   typedef enum logic [1:0] {
      TCR_SP_CTRL = 2'h0,
      TCR_SP_BUF  = 2'h1,
      TCR_SP_STAT = 2'h2
   } tcr_space_t;
   // Host access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      tcr_space_t space;
      logic [3:0] addr;
      logic [7:0] wdata;
   } tcr_req_t;
   // Decoded configuration
   typedef struct packed {
      logic [1:0]  irq_threshold;
      logic        pll_wide;
      logic        band_select;
      logic [2:0]  op_mode;
      logic        transparent;
      logic [6:0]  synth_word_a_low_part;
      logic        poll_mode;
      logic [12:0] synth_word_a;
   } tcr_cfg_t;
endpackage
`default_nettype wire

// >>> hw/tcr_ctrl_file.sv
// Eight control registers with defaults loaded at power-on.
// Assumes writes come already qualified by the powered state.
`default_nettype none
module tcr_ctrl_file #(
   parameter int COUNT = tcr_pkg::CTRL_COUNT
) (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   input  wire logic                clear,
   // Access
   input  wire logic                wr_en,
   input  wire logic [3:0]          wr_addr,
   input  wire logic [7:0]          wr_data,
   output logic [COUNT-1:0][7:0]    regs
);
   // ==========================================================
   // Storage
   genvar i;
   generate
      for (i = 0; i < COUNT; i++) begin : g_reg
         localparam logic [7:0] RST_VAL =
            (i == 0) ? tcr_pkg::CTRL1_RESET :
            (i == 1) ? tcr_pkg::CTRL2_RESET :
            (i == 2) ? tcr_pkg::CTRL3_RESET : tcr_pkg::CTRL_OTHER_RESET;
         wire logic hit = wr_en && (wr_addr == 4'(i));
         logic [7:0] val_reg;
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               val_reg <= RST_VAL;
            end else if (clk_en) begin
               if (clear) begin
                  val_reg <= RST_VAL;
               end else if (hit) begin
                  val_reg <= wr_data;
               end
            end
         end
         assign regs[i] = val_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// >>> hw/tcr_data_buf.sv
// Sixteen-byte transmit/receive data buffer with fill count.
// Assumes the host side and the radio side never push and pop wrongly.
`default_nettype none
module tcr_data_buf #(
   parameter int DEPTH = tcr_pkg::BUF_DEPTH
) (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   input  wire logic                      clear,
   // Write side
   input  wire logic                      push,
   input  wire logic [7:0]                push_data,
   // Read side
   input  wire logic                      pop,
   output logic [7:0]                     pop_data,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0]     count
);
   localparam int AW = $clog2(DEPTH);
   logic [7:0]    mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [$clog2(DEPTH+1)-1:0] cnt_reg;
   wire logic do_push = push && (cnt_reg != ($clog2(DEPTH+1))'(DEPTH));
   wire logic do_pop  = pop && (cnt_reg != '0);

   // ==========================================================
   // Pointers and count
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wp_reg   <= '0;
         rp_reg   <= '0;
         cnt_reg  <= '0;
         pop_data <= 8'h00;
      end else if (clk_en) begin
         if (clear) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
         end else begin
            if (do_push) wp_reg <= wp_reg + 1'b1;
            if (do_pop) begin
               rp_reg   <= rp_reg + 1'b1;
               pop_data <= mem[rp_reg];
            end
            if (do_push && !do_pop) cnt_reg <= cnt_reg + 1'b1;
            else if (do_pop && !do_push) cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (clk_en && do_push) mem[wp_reg] <= push_data;
   end
   assign count = cnt_reg;
endmodule
`default_nettype wire

// >>> hw/tcr_config_regs.sv
// Top of the configuration register bank: power state, storage, decode, interrupt.
// Assumes the serial interface shift logic presents decoded byte requests.
`default_nettype none
module tcr_config_regs (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              clk_en,
   // Power pins and off command
   input  wire logic              power_on_pin,
   input  wire logic              power_button_n,
   input  wire logic              off_cmd,
   // Host request
   input  var  tcr_pkg::tcr_req_t req,
   output logic [7:0]             rdata,
   // Radio side buffer access
   input  wire logic              radio_push,
   input  wire logic [7:0]        radio_push_data,
   input  wire logic              radio_pop,
   output logic [7:0]             radio_pop_data,
   // Radio events and status
   input  wire logic              rx_error,
   input  wire logic              bit_check_ok,
   input  wire logic              tx_empty,
   input  wire logic [7:0]        status_in,
   // Transparent streaming
   input  wire logic              serial_in_tx_mod,
   input  wire logic              rx_mod_data,
   output logic                   tx_mod_data,
   output logic                   serial_out_rx_mod,
   // Decoded configuration
   output var  tcr_pkg::tcr_cfg_t cfg,
   output logic                   manchester_en,
   output logic                   powered,
   output logic                   irq
);
   localparam int CW = $clog2(tcr_pkg::BUF_DEPTH + 1);

   // ==========================================================
   // Power state
   logic powered_reg;
   wire logic wake = power_on_pin || !power_button_n;
   wire logic go_off = powered_reg && off_cmd && !wake;
   wire logic go_on = !powered_reg && wake;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         powered_reg <= 1'b0;
      end else if (clk_en) begin
         if (go_on) powered_reg <= 1'b1;
         else if (go_off) powered_reg <= 1'b0;
      end
   end
   assign powered = powered_reg;
   wire logic wipe = go_on || go_off;

   // ==========================================================
   // Request qualification
   // ignore while off
   wire logic acc_wr = powered_reg && req.wr;
   wire logic acc_rd = powered_reg && req.rd;
   wire logic ctrl_wr = acc_wr && (req.space == tcr_pkg::TCR_SP_CTRL);
   wire logic [7:0] ctrl_mode_irq;

   // ==========================================================
   // Control registers
   logic [tcr_pkg::CTRL_COUNT-1:0][7:0] ctrl;
   tcr_ctrl_file #(.COUNT(tcr_pkg::CTRL_COUNT)) u_ctrl (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .clear   (wipe),
      .wr_en   (ctrl_wr),
      // Writes alias on the low three address bits, the same way reads do.
      .wr_addr ({1'b0, req.addr[2:0]}),
      .wr_data (req.wdata),
      .regs    (ctrl)
   );
   assign ctrl_mode_irq = ctrl[tcr_pkg::CTRL_MODE_IRQ_ADR];
   wire logic [7:0] control_synth_word_a_low  = ctrl[tcr_pkg::CTRL_SYNTH_WORD_A_LOW_ADR];
   wire logic [7:0] control_synth_word_a_high = ctrl[tcr_pkg::CTRL_SYNTH_WORD_A_HIGH_ADR];

   // ==========================================================
   // Field decode
   wire logic [1:0] irq_threshold =
      {ctrl_mode_irq[tcr_pkg::IRQ_THR_HI], ctrl_mode_irq[tcr_pkg::IRQ_THR_LO]};
   wire logic       pll_wide    = ctrl_mode_irq[tcr_pkg::RANGE_BIT];
   wire logic       band_select = ctrl_mode_irq[tcr_pkg::BAND_BIT];
   wire logic [2:0] op_mode     = ctrl_mode_irq[tcr_pkg::MODE_HI:tcr_pkg::MODE_LO];
   wire logic       transparent = ctrl_mode_irq[tcr_pkg::TRANSP_BIT];
   wire logic [6:0] synth_word_a_low_part =
      control_synth_word_a_low[tcr_pkg::SYNTH_WORD_A_LOW_HI:tcr_pkg::SYNTH_WORD_A_LOW_LO];
   wire logic       poll_mode   = control_synth_word_a_low[tcr_pkg::POLL_BIT];
   wire logic [5:0] synth_word_a_high_raw =
      control_synth_word_a_high[tcr_pkg::SYNTH_WORD_A_HIGH_HI:tcr_pkg::SYNTH_WORD_A_HIGH_LO];
   wire logic [2:0] synth_word_a_high_narrow = synth_word_a_high_raw[tcr_pkg::NARROW_BITS-1:0];

   wire logic is_tx  = powered_reg && (op_mode == tcr_pkg::TCR_TX);
   wire logic is_rx  = powered_reg && ((op_mode == tcr_pkg::TCR_RX) ||
                                       (op_mode == tcr_pkg::TCR_RX_POLL));

   // ==========================================================
   // Synthesizer word
   // range select
   wire logic [12:0] synth_word_a_high_part = pll_wide ?
      {synth_word_a_high_raw, 7'h00} :
      (tcr_pkg::NARROW_BASE | {3'h0, synth_word_a_high_narrow, 7'h00});
   wire logic [12:0] synth_word_a = synth_word_a_high_part + {6'h00, synth_word_a_low_part};

   assign cfg.irq_threshold = irq_threshold;
   assign cfg.pll_wide      = pll_wide;
   assign cfg.band_select   = band_select;
   assign cfg.op_mode       = op_mode;
   assign cfg.transparent   = transparent;
   assign cfg.synth_word_a_low_part = synth_word_a_low_part;
   assign cfg.poll_mode     = poll_mode;
   assign cfg.synth_word_a  = synth_word_a;

   assign manchester_en = is_tx && !poll_mode;

   // ==========================================================
   // Data buffer
   wire logic buf_en   = powered_reg && !transparent;
   wire logic host_buf = req.space == tcr_pkg::TCR_SP_BUF;
   wire logic push = buf_en && ((acc_wr && host_buf) || radio_push);
   wire logic pop  = buf_en && ((acc_rd && host_buf) || radio_pop);
   wire logic [7:0] push_data = (acc_wr && host_buf) ? req.wdata : radio_push_data;
   logic [7:0]    buf_q;
   logic [CW-1:0] fill;
   tcr_data_buf #(.DEPTH(tcr_pkg::BUF_DEPTH)) u_buf (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .clear     (wipe),
      .push      (push),
      .push_data (push_data),
      .pop       (pop),
      .pop_data  (buf_q),
      .count     (fill)
   );
   assign radio_pop_data = buf_q;

   assign tx_mod_data       = transparent && is_tx && serial_in_tx_mod;
   assign serial_out_rx_mod = transparent && is_rx && rx_mod_data;

   // ==========================================================
   // Status register
   logic [7:0] status_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_reg <= 8'h00;
      end else if (clk_en) begin
         status_reg <= powered_reg ? status_in : 8'h00;
      end
   end

   // ==========================================================
   // Read data
   wire logic [7:0] rd_sel =
      (req.space == tcr_pkg::TCR_SP_CTRL) ? ctrl[req.addr[2:0]] :
      (req.space == tcr_pkg::TCR_SP_STAT) ? status_reg : 8'h00;
   logic rd_buf_reg;
   logic [7:0] rd_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_reg     <= 8'h00;
         rd_buf_reg <= 1'b0;
      end else if (clk_en) begin
         rd_buf_reg <= acc_rd && host_buf;
         if (acc_rd) rd_reg <= rd_sel;
      end
   end
   assign rdata = rd_buf_reg ? buf_q : rd_reg;

   // ==========================================================
   // Interrupt
   wire logic [4:0] thr =
      (irq_threshold == 2'h0) ? tcr_pkg::THR_0 :
      (irq_threshold == 2'h1) ? tcr_pkg::THR_1 :
      (irq_threshold == 2'h2) ? tcr_pkg::THR_2 : tcr_pkg::THR_3;
   wire logic [4:0] fill5 = 5'(fill);
   wire logic rx_irq = is_rx && (((fill5 >= thr) && !transparent) || rx_error ||
                                 (bit_check_ok && !poll_mode));
   wire logic tx_irq = is_tx && !transparent && ((fill5 <= thr) || tx_empty);
   logic irq_reg;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else if (clk_en) begin
         irq_reg <= rx_irq || tx_irq;
      end
   end
   assign irq = irq_reg;

   // ==========================================================
   // Checks
   // off ignores writes
   off_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && !powered_reg && !wake && req.wr) |=> $stable(ctrl))
      else $error("control changed while off");
   wake_default_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && go_on) |=> (ctrl_mode_irq == tcr_pkg::CTRL1_RESET &&
      control_synth_word_a_low == tcr_pkg::CTRL2_RESET &&
      control_synth_word_a_high == tcr_pkg::CTRL3_RESET))
      else $error("defaults not loaded at power on");
   write_back_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && ctrl_wr && !wipe) |=> (ctrl[$past(req.addr[2:0])] == $past(req.wdata)))
      else $error("control register not written");
   duplex_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && powered_reg && op_mode[2]) |=> !irq)
      else $error("interrupt in duplex mode");
   narrow_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !pll_wide |-> (synth_word_a >= tcr_pkg::NARROW_BASE && synth_word_a <= 13'hfff))
      else $error("word outside narrow range");
   rx_thresh_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && is_rx && !transparent && fill5 >= thr) |=> irq)
      else $error("receive threshold missed");
   manch_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      manchester_en == (powered_reg && op_mode == tcr_pkg::TCR_TX && !poll_mode))
      else $error("manchester select wrong");
   transp_bypass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (clk_en && transparent && req.wr && host_buf && !wipe) |=> $stable(fill))
      else $error("buffer used in transparent mode");
endmodule
`default_nettype wire

// >>> bench/tcr_host_model.sv
// Host controller model that issues byte requests to the register bank.
// Assumes it is called at a falling edge and that the bank answers on the next edge.
`default_nettype none
module tcr_host_model (
   // Clock
   input  wire logic              sys_clk,
   // Request and answer
   output var  tcr_pkg::tcr_req_t req,
   input  wire logic [7:0]        rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial req = '0;

   // ==========================================
   // Single transfer
   // Request held across one rising edge, answer taken after it, then one idle edge
   // so that back-to-back calls never reassign the strobe within one time step.
   task automatic xfer(input bit wr, input logic [1:0] sp, input logic [3:0] adr,
                       input logic [7:0] wd, output logic [7:0] q);
      req.wr    = wr;
      req.rd    = !wr;
      req.space = tcr_pkg::tcr_space_t'(sp);
      req.addr  = adr;
      req.wdata = wd;
      @(negedge sys_clk);
      q         = rdata;
      req.wr    = 1'b0;
      req.rd    = 1'b0;
      @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// >>> bench/tcr_config_regs_bench.sv
// Self-checking bench of the configuration register bank.
// Assumes the bank and the host model compile beforehand.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module tcr_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Stimulus and observed signals
   logic sys_clk = 0, sys_rst = 1, clk_en = 1;
   logic power_on_pin = 0, power_button_n = 1, off_cmd = 0;
   logic radio_push = 0, radio_pop = 0, rx_error = 0, bit_check_ok = 0, tx_empty = 0;
   logic serial_in_tx_mod = 0, rx_mod_data = 0;
   logic [7:0] radio_push_data = 8'h00, status_in = 8'h00;
   logic [7:0] rdata, radio_pop_data;
   logic tx_mod_data, serial_out_rx_mod, manchester_en, powered, irq;
   tcr_pkg::tcr_req_t req;
   tcr_pkg::tcr_cfg_t cfg;
   int bad_count = 0, checked = 0;
   logic [4:0] thr_tab [4] = '{tcr_pkg::THR_0, tcr_pkg::THR_1, tcr_pkg::THR_2, tcr_pkg::THR_3};

   always #50 sys_clk = ~sys_clk;

   tcr_config_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .power_on_pin(power_on_pin), .power_button_n(power_button_n), .off_cmd(off_cmd),
      .req(req), .rdata(rdata), .radio_push(radio_push), .radio_push_data(radio_push_data),
      .radio_pop(radio_pop), .radio_pop_data(radio_pop_data), .rx_error(rx_error),
      .bit_check_ok(bit_check_ok), .tx_empty(tx_empty), .status_in(status_in),
      .serial_in_tx_mod(serial_in_tx_mod), .rx_mod_data(rx_mod_data),
      .tx_mod_data(tx_mod_data), .serial_out_rx_mod(serial_out_rx_mod), .cfg(cfg),
      .manchester_en(manchester_en), .powered(powered), .irq(irq));

   tcr_host_model host_u (.sys_clk(sys_clk), .req(req), .rdata(rdata));

   // ==========================================
   // Shared helpers
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [1:0] sp, input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_u.xfer(1'b1, sp, a, d, q);
   endtask
   task automatic rdchk(input logic [1:0] sp, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      host_u.xfer(1'b0, sp, a, 8'h00, q);
      `CHK(q, e)
   endtask
   task automatic push(input logic [7:0] d);
      radio_push = 1'b1;
      radio_push_data = d;
      tick(1);
      radio_push = 1'b0;
      tick(1);
   endtask
   task automatic pop_chk(input logic [7:0] e);
      radio_pop = 1'b1;
      tick(1);
      radio_pop = 1'b0;
      `CHK(radio_pop_data, e)
      tick(1);
   endtask
   task automatic wake(input bit by_button);
      if (by_button) power_button_n = 1'b0; else power_on_pin = 1'b1;
      tick(1);
      power_button_n = 1'b1;
      power_on_pin = 1'b0;
      tick(1);
      `CHK(powered, 1'b1)
   endtask
   task automatic stop_test;
      if (bad_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_off_defaults;
      `CHK(powered, 1'b0)
      wr(2'h0, 4'h0, 8'h12);
      wake(1'b0);
      rdchk(2'h0, 4'h0, 8'h80);
      rdchk(2'h0, 4'h1, 8'ha8);
      rdchk(2'h0, 4'h2, 8'h7b);
      `CHK(cfg.irq_threshold, 2'b10)
      `CHK(cfg.synth_word_a_low_part, 7'd84)
      `CHK(cfg.synth_word_a, 13'd3924)
   endtask
   task automatic t_modes;
      for (int m = 0; m < 8; m++) begin
         wr(2'h0, 4'h0, {4'h8, 3'(m), 1'b0});
         rdchk(2'h0, 4'h0, {4'h8, 3'(m), 1'b0});
         `CHK(cfg.op_mode, 3'(m))
      end
      for (int a = 3; a < 8; a++) begin
         wr(2'h0, 4'(a), 8'h30 + 8'(a));
         rdchk(2'h0, 4'(a), 8'h30 + 8'(a));
      end
      wr(2'h0, 4'h0, 8'h80);
   endtask
   task automatic t_synth_word_a;
      wr(2'h0, 4'h2, 8'hfc);
      wr(2'h0, 4'h1, 8'hff);
      wr(2'h0, 4'h0, 8'hb0);
      `CHK(cfg.synth_word_a, 13'd8191)
      `CHK(cfg.band_select, 1'b1)
      wr(2'h0, 4'h0, 8'h80);
      `CHK(cfg.synth_word_a, 13'd4095)
      `CHK(cfg.band_select, 1'b0)
      wr(2'h0, 4'h2, 8'h7b);
      wr(2'h0, 4'h1, 8'ha8);
   endtask
   task automatic t_rx;
      for (int c = 0; c < 4; c++) begin
         wr(2'h0, 4'h0, {2'(c), 6'h06});
         for (int i = 1; i < thr_tab[c]; i++) push(8'h40 + 8'(i));
         tick(1);
         `CHK(irq, 1'b0)
         push(8'h40 + 8'(thr_tab[c]));
         tick(1);
         `CHK(irq, 1'b1)
         for (int i = 1; i <= thr_tab[c]; i++) rdchk(2'h1, 4'h0, 8'h40 + 8'(i));
         tick(1);
         `CHK(irq, 1'b0)
      end
      rx_error = 1'b1;
      tick(2);
      `CHK(irq, 1'b1)
      rx_error = 1'b0;
      bit_check_ok = 1'b1;
      tick(2);
      `CHK(irq, 1'b1)
      wr(2'h0, 4'h1, 8'ha9);
      tick(2);
      `CHK(irq, 1'b0)
      bit_check_ok = 1'b0;
      wr(2'h0, 4'h1, 8'ha8);
   endtask
   task automatic t_tx;
      wr(2'h0, 4'h0, 8'h82);
      `CHK(manchester_en, 1'b1)
      wr(2'h0, 4'h1, 8'ha9);
      `CHK(manchester_en, 1'b0)
      wr(2'h0, 4'h1, 8'ha8);
      for (int i = 0; i < 5; i++) wr(2'h1, 4'h0, 8'h60 + 8'(i));
      tick(2);
      `CHK(irq, 1'b0)
      pop_chk(8'h60);
      tick(1);
      `CHK(irq, 1'b1)
      for (int i = 1; i < 5; i++) pop_chk(8'h60 + 8'(i));
      wr(2'h0, 4'h0, 8'h02);
      wr(2'h1, 4'h0, 8'h11);
      wr(2'h1, 4'h0, 8'h22);
      tick(2);
      `CHK(irq, 1'b0)
      tx_empty = 1'b1;
      tick(2);
      `CHK(irq, 1'b1)
      tx_empty = 1'b0;
      pop_chk(8'h11);
      pop_chk(8'h22);
   endtask
   task automatic t_duplex;
      for (int k = 0; k < 2; k++) begin
         wr(2'h0, 4'h0, k ? 8'h0e : 8'h0a);
         for (int i = 0; i < 3; i++) push(8'h70 + 8'(i));
         tick(2);
         `CHK(irq, 1'b0)
         bit_check_ok = 1'b1;
         tick(2);
         `CHK(irq, 1'b0)
         bit_check_ok = 1'b0;
         for (int i = 0; i < 3; i++) rdchk(2'h1, 4'h0, 8'h70 + 8'(i));
      end
   endtask
   task automatic t_transparent;
      wr(2'h0, 4'h0, 8'h83);
      for (int v = 0; v < 2; v++) begin
         serial_in_tx_mod = 1'(v);
         rx_mod_data = 1'(!v);
         tick(1);
         `CHK(tx_mod_data, 1'(v))
         `CHK(serial_out_rx_mod, 1'b0)
      end
      wr(2'h0, 4'h0, 8'h07);
      for (int v = 0; v < 2; v++) begin
         rx_mod_data = 1'(v);
         tick(1);
         `CHK(serial_out_rx_mod, 1'(v))
         `CHK(tx_mod_data, 1'b0)
      end
      wr(2'h1, 4'h0, 8'h99);
      wr(2'h0, 4'h0, 8'h06);
      tick(2);
      `CHK(irq, 1'b0)
      wr(2'h0, 4'h0, 8'h80);
   endtask
   task automatic t_status;
      status_in = 8'h5a;
      tick(1);
      rdchk(2'h2, 4'h0, 8'h5a);
      status_in = 8'ha5;
      tick(1);
      rdchk(2'h2, 4'h0, 8'ha5);
      clk_en = 1'b0;
      status_in = 8'h3c;
      tick(2);
      clk_en = 1'b1;
      rdchk(2'h2, 4'h0, 8'ha5);
      rdchk(2'h2, 4'h0, 8'h3c);
   endtask
   task automatic t_power_cycle;
      wr(2'h0, 4'h0, 8'h3c);
      rdchk(2'h0, 4'h0, 8'h3c);
      push(8'h5c);
      off_cmd = 1'b1;
      tick(1);
      off_cmd = 1'b0;
      tick(1);
      `CHK(powered, 1'b0)
      wake(1'b1);
      rdchk(2'h0, 4'h0, 8'h80);
      wr(2'h0, 4'h0, 8'h06);
      tick(2);
      `CHK(irq, 1'b0)
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial begin
      tick(5);
      sys_rst = 1'b0;
      tick(1);
      t_off_defaults();
      t_modes();
      t_synth_word_a();
      t_rx();
      t_tx();
      t_duplex();
      t_transparent();
      t_status();
      t_power_cycle();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
